// File: core/pwm_out_params.svh
// register offsets, field positions, reset values and codes for the pwm output stage
`ifndef PWM_OUT_PARAMS_SVH
`define PWM_OUT_PARAMS_SVH
`define ADDR_OUTPUT_PIN_CONTROL 4'h0
`define ADDR_ADC_TRIGGER_COMPARE 4'h1
`define ADDR_FAULT_LIMIT_CONTROL 4'h2
`define ADDR_STAGE_CONTROL 4'h3
`define ADDR_STAGE_STATUS 4'h4
`define RST_OUTPUT_PIN_CONTROL 16'hC000
`define RST_ADC_TRIGGER_COMPARE 16'h0000
`define RST_FAULT_LIMIT_CONTROL 16'h00F8
`define RST_STAGE_CONTROL 16'h0000
`define BIT_HIGH_PIN_OWNER 15
`define BIT_LOW_PIN_OWNER 14
`define BIT_HIGH_PIN_INVERT 13
`define BIT_LOW_PIN_INVERT 12
`define MSB_PAIR_MODE 11
`define LSB_PAIR_MODE 10
`define BIT_HIGH_FORCE_ENABLE 9
`define BIT_LOW_FORCE_ENABLE 8
`define MSB_FORCE_VALUE 7
`define LSB_FORCE_VALUE 6
`define MSB_TRIP_VALUE 5
`define LSB_TRIP_VALUE 4
`define MSB_LIMIT_VALUE 3
`define LSB_LIMIT_VALUE 2
`define BIT_SWAP 1
`define BIT_FORCE_SYNC 0
`define MSB_LIMIT_SOURCE 14
`define LSB_LIMIT_SOURCE 10
`define BIT_LIMIT_INVERT 9
`define BIT_LIMIT_ENABLE 8
`define MSB_TRIP_SOURCE 7
`define LSB_TRIP_SOURCE 3
`define BIT_TRIP_INVERT 2
`define MSB_TRIP_MODE 1
`define LSB_TRIP_MODE 0
`define FCL_WRITE_MASK 16'h7FFF
`define BIT_CTRL_ENABLE 0
`define BIT_CTRL_CENTER 1
`define BIT_CTRL_UNLOCK 2
`define BIT_CTRL_TRIP_CLEAR 3
`define SRC_FAULT1 5'h00
`define SRC_FAULT4 5'h03
`define SRC_CMP1 5'h08
`define SRC_CMP4 5'h0B
`define SRC_FAULT32 5'h1F
`endif

// File: core/pwm_out_pkg.sv
// types shared by the pwm output stage files
package pwm_out_pkg;
  typedef enum logic [1:0] {
    PAIR_COMPLEMENTARY = 2'h0,
    PAIR_REDUNDANT = 2'h1,
    PAIR_PUSH_PULL = 2'h2,
    PAIR_RESERVED = 2'h3
  } pair_mode_t;
  typedef enum logic [1:0] {
    TRIP_LATCHED = 2'h0,
    TRIP_CYCLE = 2'h1,
    TRIP_RSVD = 2'h2,
    TRIP_OFF = 2'h3
  } trip_mode_t;
  typedef enum logic [2:0] {
    TRIP_IDLE = 3'b001,
    TRIP_ACTIVE = 3'b010,
    TRIP_HOLD = 3'b100
  } trip_state_t;
  // high/low pair travelling together
  typedef struct packed {
    logic high;
    logic low;
  } pin_pair_t;
  // source inputs: fault pins 1..4, comparators 1..4, fault 32
  typedef struct packed {
    logic [3:0] fault;
    logic [3:0] cmp;
    logic fault32;
  } src_bus_t;
endpackage

// File: core/source_select.sv
// decodes one five-bit source code onto the fault/comparator inputs with polarity
`timescale 1ns/1ps
`include "pwm_out_params.svh"
module source_select (
  input wire pwm_out_pkg::src_bus_t sources_in,
  input wire logic [4:0] code_in,
  input wire logic invert_in,
  output logic active_out
);
  wire logic is_fault;
  wire logic is_cmp;
  wire logic is_f32;
  wire logic raw;
  // reserved codes select nothing and read as inactive in either polarity
  assign is_fault = (code_in <= `SRC_FAULT4);
  assign is_cmp = (code_in >= `SRC_CMP1) && (code_in <= `SRC_CMP4);
  assign is_f32 = (code_in == `SRC_FAULT32);
  assign raw = is_fault ? sources_in.fault[code_in[1:0]] :
               is_cmp ? sources_in.cmp[code_in[1:0]] :
               is_f32 ? sources_in.fault32 : 1'b0;
  assign active_out = (is_fault | is_cmp | is_f32) & (raw ^ invert_in);
endmodule

// File: core/pwm_output_fault_control.sv
// output stage of one pwm channel: pin mapping, override, fault and limit forcing
`timescale 1ns/1ps
`include "pwm_out_params.svh"
module pwm_output_fault_control (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  input wire logic write_lock_config_in,
  input wire logic pwm_raw_in,
  input wire logic [15:0] time_base_in,
  input wire logic [15:0] phase_shift_value_in,
  input wire logic period_boundary_in,
  input wire pwm_out_pkg::src_bus_t sources_in,
  input wire logic [1:0] gpio_data_in,
  output pwm_out_pkg::pin_pair_t pins_out,
  output logic [1:0] pin_owner_out,
  output logic adc_trigger_out
);
  logic [15:0] pin_ctrl_r;
  logic [15:0] adc_cmp_r;
  logic [15:0] fcl_r;
  logic [1:0] stage_ctrl_r;
  logic unlocked_r;
  logic [1:0] force_applied_r;
  pwm_out_pkg::trip_state_t trip_state_r;
  pwm_out_pkg::trip_state_t trip_state_nxt;
  pwm_out_pkg::src_bus_t src_s1_r;
  pwm_out_pkg::src_bus_t src_s2_r;
  pwm_out_pkg::pin_pair_t pins_r;
  logic [15:0] rdata_r;
  logic trig_r;
  wire logic wr_pin;
  wire logic wr_cmp;
  wire logic wr_fcl;
  wire logic wr_ctrl;
  wire logic pin_write_ok;
  wire logic trip_clear;
  wire logic module_global_enable;
  wire logic center_aligned;
  wire logic force_sync;
  wire logic sync_point;
  wire logic limit_raw;
  wire logic trip_raw;
  wire logic limit_active;
  wire logic trip_active;
  wire pwm_out_pkg::pair_mode_t pair_output_mode;
  wire pwm_out_pkg::trip_mode_t trip_mode;
  wire pwm_out_pkg::pin_pair_t gen_pair;
  wire pwm_out_pkg::pin_pair_t mapped_pair;
  wire pwm_out_pkg::pin_pair_t final_pair;
  wire logic [1:0] force_enable;
  wire logic [1:0] force_value;
  wire logic [1:0] trip_value;
  wire logic [1:0] limit_value;
  logic [15:0] rdata_nxt;

  // named decode wires for bus actions, fault/limit fields and per-pin vectors
  wire logic pin_write_take;
  wire logic ctrl_unlock;
  wire logic [4:0] limit_source_select;
  wire logic [4:0] trip_source_select;
  wire logic limit_input_invert;
  wire logic trip_input_invert;
  wire logic limit_enable;
  wire logic trip_armed;
  wire logic trip_disabled;
  wire logic cycle_release;
  wire logic latch_release;
  wire logic force_update;
  wire logic adc_match;
  wire logic swap_sel;
  wire logic [1:0] pin_owner;
  wire logic [1:0] pin_invert;
  wire logic [1:0] mapped_vec;
  wire logic [1:0] forced_vec;
  wire logic [1:0] final_vec;
  wire logic [15:0] status_word;
  genvar pin_idx;

  // register decode
  assign wr_pin = reg_write_in && (reg_addr_in == `ADDR_OUTPUT_PIN_CONTROL);
  assign wr_cmp = reg_write_in && (reg_addr_in == `ADDR_ADC_TRIGGER_COMPARE);
  assign wr_fcl = reg_write_in && (reg_addr_in == `ADDR_FAULT_LIMIT_CONTROL);
  assign wr_ctrl = reg_write_in && (reg_addr_in == `ADDR_STAGE_CONTROL);
  // lock applies to the pin control register only; unlock is consumed by one write
  assign pin_write_ok = !write_lock_config_in || unlocked_r;
  assign trip_clear = wr_ctrl && reg_wdata_in[`BIT_CTRL_TRIP_CLEAR];
  // unlock is armed by a control write and spent by the next pin control write
  assign ctrl_unlock = wr_ctrl && reg_wdata_in[`BIT_CTRL_UNLOCK];
  assign pin_write_take = wr_pin && pin_write_ok;
  assign module_global_enable = stage_ctrl_r[`BIT_CTRL_ENABLE];
  assign center_aligned = stage_ctrl_r[`BIT_CTRL_CENTER];

  // field views
  assign pair_output_mode =
    pwm_out_pkg::pair_mode_t'(pin_ctrl_r[`MSB_PAIR_MODE:`LSB_PAIR_MODE]);
  assign trip_mode = pwm_out_pkg::trip_mode_t'(fcl_r[`MSB_TRIP_MODE:`LSB_TRIP_MODE]);
  assign force_enable = {pin_ctrl_r[`BIT_HIGH_FORCE_ENABLE], pin_ctrl_r[`BIT_LOW_FORCE_ENABLE]};
  assign force_value = pin_ctrl_r[`MSB_FORCE_VALUE:`LSB_FORCE_VALUE];
  assign trip_value = pin_ctrl_r[`MSB_TRIP_VALUE:`LSB_TRIP_VALUE];
  assign limit_value = pin_ctrl_r[`MSB_LIMIT_VALUE:`LSB_LIMIT_VALUE];
  assign force_sync = pin_ctrl_r[`BIT_FORCE_SYNC];
  assign swap_sel = pin_ctrl_r[`BIT_SWAP];
  assign pin_owner = {pin_ctrl_r[`BIT_HIGH_PIN_OWNER], pin_ctrl_r[`BIT_LOW_PIN_OWNER]};
  assign pin_invert = {pin_ctrl_r[`BIT_HIGH_PIN_INVERT], pin_ctrl_r[`BIT_LOW_PIN_INVERT]};

  // fault/limit field views; polarity is only safe to change while stopped
  assign limit_source_select = fcl_r[`MSB_LIMIT_SOURCE:`LSB_LIMIT_SOURCE];
  assign trip_source_select = fcl_r[`MSB_TRIP_SOURCE:`LSB_TRIP_SOURCE];
  assign limit_input_invert = fcl_r[`BIT_LIMIT_INVERT];
  assign trip_input_invert = fcl_r[`BIT_TRIP_INVERT];
  assign limit_enable = fcl_r[`BIT_LIMIT_ENABLE];

  // register writes; trip source resets to fault 32, limit source to fault 1
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pin_ctrl_r <= `RST_OUTPUT_PIN_CONTROL;
      adc_cmp_r <= `RST_ADC_TRIGGER_COMPARE;
      fcl_r <= `RST_FAULT_LIMIT_CONTROL;
      stage_ctrl_r <= 2'(`RST_STAGE_CONTROL);
      unlocked_r <= 1'b0;
    end
    else if (enable_in)
    begin
      if (pin_write_take)
        pin_ctrl_r <= reg_wdata_in;
      if (wr_cmp)
        adc_cmp_r <= reg_wdata_in;
      if (wr_fcl)
        fcl_r <= reg_wdata_in & `FCL_WRITE_MASK;
      if (wr_ctrl)
        stage_ctrl_r <= reg_wdata_in[1:0];
      if (ctrl_unlock)
        unlocked_r <= 1'b1;
      else if (wr_pin)
        unlocked_r <= 1'b0;
    end
  end

  // two-flop synchroniser on the asynchronous fault and comparator inputs
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      src_s1_r <= '0;
      src_s2_r <= '0;
    end
    else if (enable_in)
    begin
      src_s1_r <= sources_in;
      src_s2_r <= src_s1_r;
    end
  end

  source_select limit_sel (
    .sources_in(src_s2_r),
    .code_in(limit_source_select),
    .invert_in(limit_input_invert),
    .active_out(limit_raw)
  );
  source_select trip_sel (
    .sources_in(src_s2_r),
    .code_in(trip_source_select),
    .invert_in(trip_input_invert),
    .active_out(trip_raw)
  );

  // limit forcing only when enabled, no latching
  assign limit_active = limit_raw && limit_enable;

  // trip mode decode kept apart so the state machine reads as plain conditions
  assign trip_armed = (trip_mode == pwm_out_pkg::TRIP_LATCHED) ||
                      (trip_mode == pwm_out_pkg::TRIP_CYCLE);
  assign trip_disabled = !trip_armed; // reserved code behaves as off
  assign cycle_release = (trip_mode == pwm_out_pkg::TRIP_CYCLE) && period_boundary_in;
  assign latch_release = (trip_mode == pwm_out_pkg::TRIP_LATCHED) && trip_clear;

  // trip state: active while the input is asserted, then hold until release condition
  always_comb
  begin
    trip_state_nxt = trip_state_r;
    case (trip_state_r)
      pwm_out_pkg::TRIP_IDLE:
        if (trip_raw && trip_armed)
          trip_state_nxt = pwm_out_pkg::TRIP_ACTIVE;
      pwm_out_pkg::TRIP_ACTIVE:
        if (trip_disabled)
          trip_state_nxt = pwm_out_pkg::TRIP_IDLE;
        else if (!trip_raw)
          trip_state_nxt = pwm_out_pkg::TRIP_HOLD;
      pwm_out_pkg::TRIP_HOLD:
        if (trip_raw)
          trip_state_nxt = pwm_out_pkg::TRIP_ACTIVE; // new event beats a clear
        else if (trip_disabled)
          trip_state_nxt = pwm_out_pkg::TRIP_IDLE;
        else if (cycle_release)
          trip_state_nxt = pwm_out_pkg::TRIP_IDLE;
        else if (latch_release)
          trip_state_nxt = pwm_out_pkg::TRIP_IDLE;
      default:
        trip_state_nxt = pwm_out_pkg::TRIP_IDLE;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      trip_state_r <= pwm_out_pkg::TRIP_IDLE;
    else if (enable_in)
      trip_state_r <= trip_state_nxt;
  end

  assign trip_active = (trip_state_r != pwm_out_pkg::TRIP_IDLE);

  // override sync point: zero in edge mode, phase match in center mode
  assign sync_point = center_aligned ? (time_base_in == phase_shift_value_in)
                                     : (time_base_in == 16'h0000);

  // a synced update waits up to a full period; the price of glitch-free overrides
  assign force_update = !force_sync || sync_point;

  // applied override data: immediate when unsynchronised, else at the sync point
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      force_applied_r <= 2'h0;
    else if (enable_in && force_update)
      force_applied_r <= force_value;
  end

  // pair mode: push-pull steering is left to the generator's alternate-cycle raw input
  assign gen_pair.high = (pair_output_mode == pwm_out_pkg::PAIR_RESERVED) ? 1'b0 : pwm_raw_in;
  assign gen_pair.low = (pair_output_mode == pwm_out_pkg::PAIR_COMPLEMENTARY) ? !pwm_raw_in :
                        (pair_output_mode == pwm_out_pkg::PAIR_REDUNDANT) ? pwm_raw_in :
                        (pair_output_mode == pwm_out_pkg::PAIR_PUSH_PULL) ? !pwm_raw_in :
                        1'b0;

  // swap happens before forcing so force data always names the physical pin
  assign mapped_pair.high = swap_sel ? gen_pair.low : gen_pair.high;
  assign mapped_pair.low = swap_sel ? gen_pair.high : gen_pair.low;
  assign mapped_vec = {mapped_pair.high, mapped_pair.low};

  // per pin: fault, then limit, then override, then polarity and ownership; 1 is high
  generate
    for (pin_idx = 0; pin_idx < 2; pin_idx = pin_idx + 1)
    begin : g_pin
      assign forced_vec[pin_idx] = trip_active ? trip_value[pin_idx] :
                                   limit_active ? limit_value[pin_idx] :
                                   force_enable[pin_idx] ? force_applied_r[pin_idx] :
                                   mapped_vec[pin_idx];
      assign final_vec[pin_idx] = pin_owner[pin_idx] ?
                                  (forced_vec[pin_idx] ^ pin_invert[pin_idx]) :
                                  gpio_data_in[pin_idx];
    end
  endgenerate
  assign final_pair = pwm_out_pkg::pin_pair_t'(final_vec);

  // trigger compare; only meaningful while the local time base runs
  assign adc_match = module_global_enable && (time_base_in == adc_cmp_r);

  // outputs registered so the power stage never sees decode glitches
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pins_r <= '0;
      trig_r <= 1'b0;
    end
    else if (enable_in)
    begin
      pins_r <= final_pair;
      trig_r <= adc_match;
    end
  end

  // status word: limit, trip and the override value the pins really use
  assign status_word = {12'h0000, limit_active, trip_active, force_applied_r};

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    case (reg_addr_in)
      `ADDR_OUTPUT_PIN_CONTROL: rdata_nxt = pin_ctrl_r;
      `ADDR_ADC_TRIGGER_COMPARE: rdata_nxt = adc_cmp_r;
      `ADDR_FAULT_LIMIT_CONTROL: rdata_nxt = fcl_r;
      `ADDR_STAGE_CONTROL: rdata_nxt = {13'h0000, unlocked_r, stage_ctrl_r};
      `ADDR_STAGE_STATUS: rdata_nxt = status_word;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      rdata_r <= 16'h0000;
    else if (enable_in && reg_read_in)
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata_out = rdata_r;
  assign pins_out = pins_r;
  assign pin_owner_out = pin_owner;
  assign adc_trigger_out = trig_r;
endmodule

// File: dv/power_stage_model.sv
// behavioural power stage driven by the high/low gate pair
`timescale 1ns/1ps
module power_stage_model (
  input wire logic clock_in,
  input wire pwm_out_pkg::pin_pair_t gate_in,
  output logic [1:0] level_out
);
  // bridge follows its gates one clock late, like a gate driver delay
  always_ff @(posedge clock_in)
    level_out <= {gate_in.high, gate_in.low};
endmodule

// File: dv/pwm_output_fault_control_properties.sv
// port assertions for the pwm output stage
`timescale 1ns/1ps
module pwm_out_props (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic write_lock_config_in,
  input wire logic [15:0] time_base_in,
  input wire logic [1:0] gpio_data_in,
  input wire pwm_out_pkg::pin_pair_t pins_out,
  input wire logic [1:0] pin_owner_out,
  input wire logic adc_trigger_out
);
  logic [15:0] cmp_r;
  logic run_r;
  logic unlock_r;
  wire wr_ok = reg_write_in && enable_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // shadow of compare, stage enable and unlock as seen on the bus
  always_ff @(posedge clock_in)
    if (reset_in)
    begin
      cmp_r <= 16'h0000;
      run_r <= 1'h0;
      unlock_r <= 1'h0;
    end
    else if (wr_ok && reg_addr_in == 4'h1)
      cmp_r <= reg_wdata_in;
    else if (wr_ok && reg_addr_in == 4'h3)
    begin
      run_r <= reg_wdata_in[0];
      if (reg_wdata_in[2])
        unlock_r <= 1'h1;
    end
    else if (wr_ok && reg_addr_in == 4'h0)
      unlock_r <= 1'h0;
  property p_rst; $fell(reset_in) |-> pin_owner_out == 2'h3 && pins_out == 2'h0; endproperty
  property p_hold; !(wr_ok && reg_addr_in == 4'h0) |=> $stable(pin_owner_out); endproperty
  property p_gpio; enable_in && pin_owner_out == 2'h0 |=> pins_out == $past(gpio_data_in);
  endproperty
  property p_lock;
    wr_ok && reg_addr_in == 4'h0 && write_lock_config_in && !unlock_r |=> $stable(pin_owner_out);
  endproperty
  property p_cmp; reg_read_in && enable_in && reg_addr_in == 4'h1 |=> reg_rdata_out == $past(cmp_r);
  endproperty
  property p_b15; reg_read_in && enable_in && reg_addr_in == 4'h2 |=> !reg_rdata_out[15]; endproperty
  property p_fire; enable_in && run_r && time_base_in == cmp_r |=> adc_trigger_out; endproperty
  property p_why; adc_trigger_out |-> $past(run_r) && $past(time_base_in) == $past(cmp_r);
  endproperty
  a_rst: assert property (p_rst) else $error("owner bits wrong after reset");
  a_hold: assert property (p_hold) else $error("owner bits moved without write");
  a_gpio: assert property (p_gpio) else $error("gpio data not on pins");
  a_lock: assert property (p_lock) else $error("locked write took effect");
  a_cmp: assert property (p_cmp) else $error("compare read back wrong");
  a_b15: assert property (p_b15) else $error("fault control bit 15 set");
  a_fire: assert property (p_fire) else $error("missing adc trigger");
  a_why: assert property (p_why) else $error("adc trigger without match");
  c_trig: cover property (adc_trigger_out);
  c_gpio: cover property (pin_owner_out == 2'h0);
  c_lock: cover property (wr_ok && reg_addr_in == 4'h0 && write_lock_config_in);
endmodule
bind pwm_output_fault_control pwm_out_props i_pwm_out_props (.clock_in, .reset_in, .enable_in,
  .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
  .write_lock_config_in, .time_base_in, .gpio_data_in, .pins_out, .pin_owner_out,
  .adc_trigger_out);

// File: dv/pwm_output_fault_control_tb.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
module pwm_output_fault_control_tb;
  logic clock_in = 1'h0;
  logic reset_in = 1'h1;
  logic enable_in = 1'h1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_write_in = 1'h0;
  logic reg_read_in = 1'h0;
  logic write_lock_config_in = 1'h0;
  logic pwm_raw_in = 1'h0;
  logic [15:0] time_base_in = 16'h0000;
  logic [15:0] phase_shift_value_in = 16'h0008;
  logic period_boundary_in = 1'h0;
  pwm_out_pkg::src_bus_t sources_in = 9'h000;
  logic [1:0] gpio_data_in = 2'h0;
  logic [15:0] reg_rdata_out;
  pwm_out_pkg::pin_pair_t pins_out;
  logic [1:0] pin_owner_out;
  logic adc_trigger_out;
  logic [1:0] level;
  logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h1F, 5'h04};
  int bits [10] = '{5, 6, 7, 8, 1, 2, 3, 4, 0, 0};
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  pwm_output_fault_control i_pwm_output_fault_control (.clock_in, .reset_in, .enable_in,
    .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .write_lock_config_in, .pwm_raw_in, .time_base_in, .phase_shift_value_in,
    .period_boundary_in, .sources_in, .gpio_data_in, .pins_out, .pin_owner_out,
    .adc_trigger_out);
  power_stage_model i_power_stage_model (.clock_in, .gate_in(pins_out), .level_out(level));
  always #10 clock_in = ~clock_in;
  // free-running 16-step time base; also cuts a hang short
  always @(posedge clock_in)
  begin
    time_base_in <= (time_base_in == 16'h000F) ? 16'h0000 : time_base_in + 16'h0001;
    period_boundary_in <= (time_base_in == 16'h000F);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'h1;
    @(posedge clock_in);
    reg_write_in <= 1'h0;
    // one idle edge so a following write never re-drives the strobe in this step
    @(posedge clock_in);
  endtask
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    reg_addr_in <= a;
    reg_read_in <= 1'h1;
    @(posedge clock_in);
    reg_read_in <= 1'h0;
    #1 chk(nm, reg_rdata_out, e);
  endtask
  task automatic pins(input logic [1:0] e, input int w);
    repeat (w) @(posedge clock_in);
    #1 chk("pins", {14'h0000, level}, {14'h0000, e});
  endtask
  task automatic tb_at(input logic [15:0] v);
    do @(posedge clock_in); while (time_base_in !== v);
  endtask
  // polarity changes only while the stage is stopped
  task automatic pol(input logic [15:0] d);
    wr(4'h3, 16'h0000);
    wr(4'h2, d);
    wr(4'h3, 16'h0001);
  endtask
  task automatic t_modes();
    wr(4'h3, 16'h0000);
    for (int m = 0; m < 4; m++)
      for (int r = 0; r < 2; r++)
      begin
        wr(4'h0, 16'hC000 | 16'(m << 10));
        pwm_raw_in <= r[0];
        pins((m == 3) ? 2'h0 : (m == 1) ? {r[0], r[0]} : {r[0], ~r[0]}, 4);
      end
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'hF000);
    pins(2'h1, 4);
    wr(4'h0, 16'hE000);
    pins(2'h0, 4);
    wr(4'h0, 16'hC001);
    wr(4'h0, 16'hC003);
    pins(2'h1, 20);
    wr(4'h0, 16'hC001);
  endtask
  task automatic t_over();
    wr(4'h0, 16'hC340);
    pins(2'h1, 3);
    pwm_raw_in <= 1'h0;
    wr(4'h0, 16'hC280);
    pins(2'h3, 3);
    pwm_raw_in <= 1'h1;
    wr(4'h0, 16'hC340);
    tb_at(16'h0003);
    wr(4'h0, 16'hC381);
    pins(2'h1, 4);
    tb_at(16'h0005);
    pins(2'h2, 0);
    wr(4'h3, 16'h0003);
    tb_at(16'h000A);
    wr(4'h0, 16'hC341);
    tb_at(16'h0005);
    pins(2'h2, 0);
    tb_at(16'h000D);
    pins(2'h1, 0);
    wr(4'h3, 16'h0001);
  endtask
  task automatic t_fault();
    wr(4'h0, 16'hC39C);
    wr(4'h2, 16'h0501);
    sources_in <= 9'h060;
    pins(2'h1, 8);
    sources_in <= 9'h040;
    pins(2'h3, 40);
    sources_in <= 9'h000;
    pins(2'h2, 40);
    wr(4'h2, 16'h0401);
    sources_in <= 9'h040;
    pins(2'h2, 8);
    sources_in <= 9'h000;
    pol(16'h0703);
    pins(2'h3, 8);
    pol(16'h0005);
    pins(2'h1, 8);
    pol(16'h0001);
    pins(2'h2, 40);
    for (int i = 0; i < 10; i++)
    begin
      wr(4'h2, {8'h00, codes[i], 3'h1});
      sources_in <= (i == 9) ? 9'h1FF : 9'(1 << bits[i]);
      pins((i == 9) ? 2'h2 : 2'h1, 8);
      sources_in <= 9'h000;
      pins(2'h2, 40);
    end
    wr(4'h2, 16'h0003);
    sources_in <= 9'h020;
    pins(2'h2, 8);
    wr(4'h2, 16'h0002);
    pins(2'h2, 8);
    wr(4'h2, 16'h0000);
    pins(2'h1, 8);
    sources_in <= 9'h000;
    pins(2'h1, 40);
    wr(4'h3, 16'h0009);
    pins(2'h2, 8);
  endtask
  initial
  begin
    repeat (16) @(posedge clock_in);
    reset_in <= 1'h0;
    @(posedge clock_in);
    rd(4'h0, 16'hC000, "pin_ctl");
    rd(4'h1, 16'h0000, "compare");
    rd(4'h2, 16'h00F8, "fault_ctl");
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h7FFF, "fault_ctl");
    wr(4'h2, 16'h00F8);
    t_modes();
    t_over();
    t_fault();
    wr(4'h1, 16'h0005);
    rd(4'h1, 16'h0005, "compare");
    tb_at(16'h0000);
    n = 0;
    repeat (32)
    begin
      @(posedge clock_in);
      if (adc_trigger_out === 1'h1)
        n++;
    end
    chk("triggers", 16'(n), 16'h0002);
    write_lock_config_in <= 1'h1;
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'hC39C, "locked");
    wr(4'h3, 16'h0005);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000, "unlocked");
    gpio_data_in <= 2'h2;
    pins(2'h2, 4);
    chk("owner", {14'h0000, pin_owner_out}, 16'h0000);
    final_report();
  end
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
endmodule
